// File: rtl/prs_flag_bit.sv
`timescale 1ns/1ps
module prs_flag_bit #(
  parameter bit IMPL = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic set,
  input wire logic wr,
  input wire logic wr_val,
  output logic q
);

  // Unimplemented positions stay constant zero
  always_ff @(posedge ref_clk) begin
    if (rst || clear || !IMPL) begin
      q <= prs_pkg::FLAG_RST;
    end else if (set) begin
      q <= 1'b1;
    end else if (wr) begin
      q <= wr_val;
    end
  end

endmodule

// File: rtl/prs_pkg.sv
// Function
// - Core request needs peripheral master enable set
// - Flags set on events regardless of enables
// - Enable bits 6,5,3,1,0; bits 7,4,2 zero
// - Reduced variant: ADC, capcmp, timer2 bits zero
// - ADC flag set on conversion complete
// - Capcmp flag: capture or compare, not PWM
// - Comparator flag set on output change
// - Timer2 flag set on period match
// - Timer1 flag set on counter overflow
// - Power-on bit cleared by power-on reset
// - Brown-out bit cleared by brown-out reset, only while its software enable is set
// - Brown-out bit reads zero while disabled
// - Software enable for brown-out reset function
// - Power control bits 7..2 read zero
// - Peripheral master enable gates all peripheral requests
// - Global enable gates every interrupt
package prs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_REQUEST = 8'h04;
  localparam logic [7:0] OFS_POWER = 8'h08;
  localparam logic [7:0] OFS_BO_CTRL = 8'h0c;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int BIT_ADC = 6;
  localparam int BIT_CAPCMP = 5;
  localparam int BIT_CMP = 3;
  localparam int BIT_TIMER2 = 1;
  localparam int BIT_TIMER1 = 0;
  localparam int BIT_POWER_ON = 1;
  localparam int BIT_BROWNOUT = 0;
  localparam int BIT_BO_SW_EN = 0;

  // Implemented source bits per variant
  localparam logic [7:0] MASK_FULL = 8'h6b;
  localparam logic [7:0] MASK_REDUCED = 8'h09;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic FLAG_RST = 1'b0;
  localparam logic POWER_ON_RST = 1'b0;
  localparam logic BROWNOUT_RST = 1'b0;
  localparam logic BO_SW_EN_RST = 1'b0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    CC_CAPTURE = 3'b001,
    CC_COMPARE = 3'b010,
    CC_PWM = 3'b100
  } prs_ccmode_t;

endpackage

// File: rtl/prs_top.sv
`timescale 1ns/1ps
module prs_top #(
  parameter bit FULL_VARIANT = 1'b1,
  parameter int ADDR_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic brownout_reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic global_irq_enable,
  input wire logic peripheral_master_enable,
  input wire logic adc_done,
  input wire logic [2:0] capcmp_mode,
  input wire logic capcmp_capture,
  input wire logic capcmp_match,
  input wire logic comparator_out,
  input wire logic timer2_match,
  input wire logic timer1_overflow,
  output logic core_irq,
  output logic brownout_sw_enable
);

  localparam logic [7:0] IMPL_MASK =
    FULL_VARIANT ? prs_pkg::MASK_FULL : prs_pkg::MASK_REDUCED;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic wr_enable;
  logic wr_request;
  logic wr_power;
  logic wr_bo_ctrl;
  logic [7:0] wr_data;
  logic [7:0] peripheral_irq_enable;
  logic [7:0] peripheral_irq_request;
  logic [7:0] power_control_status;
  logic [7:0] brownout_control;

  prs_wb_slave #(
    .ADDR_W(ADDR_W)
  ) u_bus (
    .ref_clk(ref_clk),
    .rst(rst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .rd_enable(peripheral_irq_enable),
    .rd_request(peripheral_irq_request),
    .rd_power(power_control_status),
    .rd_bo_ctrl(brownout_control),
    .wr_enable(wr_enable),
    .wr_request(wr_request),
    .wr_power(wr_power),
    .wr_bo_ctrl(wr_bo_ctrl),
    .wr_data(wr_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Event conditioning

  logic cmp_prev;
  logic cmp_primed;
  logic cmp_changed;
  logic capcmp_event;
  logic in_capture;
  logic in_compare;
  logic [7:0] event_set;

  // First sample after reset only primes the history, no false change
  always_ff @(posedge ref_clk) begin
    if (rst || brownout_reset) begin
      cmp_prev <= 1'b0;
      cmp_primed <= 1'b0;
    end else begin
      cmp_prev <= comparator_out;
      cmp_primed <= 1'b1;
    end
  end

  assign cmp_changed = cmp_primed && (cmp_prev != comparator_out);
  assign in_capture = capcmp_mode == prs_pkg::CC_CAPTURE;
  assign in_compare = capcmp_mode == prs_pkg::CC_COMPARE;
  // PWM mode leaves the flag alone
  assign capcmp_event = (in_capture && capcmp_capture) ||
                        (in_compare && capcmp_match);

  always_comb begin
    event_set = 8'h00;
    event_set[prs_pkg::BIT_ADC] = adc_done;
    event_set[prs_pkg::BIT_CAPCMP] = capcmp_event;
    event_set[prs_pkg::BIT_CMP] = cmp_changed;
    event_set[prs_pkg::BIT_TIMER2] = timer2_match;
    event_set[prs_pkg::BIT_TIMER1] = timer1_overflow;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable register

  logic [7:0] enable_q;

  always_ff @(posedge ref_clk) begin
    if (rst || brownout_reset) begin
      enable_q <= prs_pkg::ENABLE_RST;
    end else if (wr_enable) begin
      enable_q <= wr_data & IMPL_MASK;
    end
  end

  assign peripheral_irq_enable = enable_q & IMPL_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // Request flags, one cell per bit position

  // Flags ignore enables; software is expected to clear before enabling
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      prs_flag_bit #(
        .IMPL(IMPL_MASK[gi])
      ) u_flag (
        .ref_clk(ref_clk),
        .rst(rst),
        .clear(brownout_reset),
        .set(event_set[gi]),
        .wr(wr_request),
        .wr_val(wr_data[gi]),
        .q(peripheral_irq_request[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Power control and brown-out enable

  logic power_on_q;
  logic brownout_q;
  logic bo_sw_en_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      power_on_q <= prs_pkg::POWER_ON_RST;
    end else if (wr_power) begin
      power_on_q <= wr_data[prs_pkg::BIT_POWER_ON];
    end
  end

  // A brown-out only counts while the function is enabled
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      brownout_q <= prs_pkg::BROWNOUT_RST;
    end else if (brownout_reset && bo_sw_en_q) begin
      brownout_q <= 1'b0;
    end else if (wr_power) begin
      brownout_q <= wr_data[prs_pkg::BIT_BROWNOUT];
    end
  end

  // Enable survives its own brown-out so the next one is still caught
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bo_sw_en_q <= prs_pkg::BO_SW_EN_RST;
    end else if (wr_bo_ctrl) begin
      bo_sw_en_q <= wr_data[prs_pkg::BIT_BO_SW_EN];
    end
  end

  always_comb begin
    power_control_status = 8'h00;
    power_control_status[prs_pkg::BIT_POWER_ON] = power_on_q;
    power_control_status[prs_pkg::BIT_BROWNOUT] =
      brownout_q && bo_sw_en_q;
    brownout_control = 8'h00;
    brownout_control[prs_pkg::BIT_BO_SW_EN] = bo_sw_en_q;
  end

  assign brownout_sw_enable = bo_sw_en_q;

  ////////////////////////////////////////////////////////////////////////////
  // Core request

  logic any_pending;
  logic next_core_irq;

  assign any_pending = |(peripheral_irq_request & peripheral_irq_enable);
  assign next_core_irq = global_irq_enable &&
                         peripheral_master_enable &&
                         any_pending;

  // Registered to keep the core input glitch free
  always_ff @(posedge ref_clk) begin
    if (rst || brownout_reset) begin
      core_irq <= 1'b0;
    end else begin
      core_irq <= next_core_irq;
    end
  end

endmodule

// File: rtl/prs_wb_slave.sv
`timescale 1ns/1ps
module prs_wb_slave #(
  parameter int ADDR_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] rd_enable,
  input wire logic [7:0] rd_request,
  input wire logic [7:0] rd_power,
  input wire logic [7:0] rd_bo_ctrl,
  output logic wr_enable,
  output logic wr_request,
  output logic wr_power,
  output logic wr_bo_ctrl,
  output logic [7:0] wr_data
);

  logic req;
  logic wr_go;
  logic hit_enable;
  logic hit_request;
  logic hit_power;
  logic hit_bo_ctrl;
  logic [7:0] rd_mux;

  assign req = wb_cyc_i && wb_stb_i;
  // Write lands on the acknowledging edge; unmapped writes vanish
  assign wr_go = req && wb_ack_o && wb_we_i && wb_sel_i[0];
  assign hit_enable = wb_adr_i == prs_pkg::OFS_ENABLE[ADDR_W-1:0];
  assign hit_request = wb_adr_i == prs_pkg::OFS_REQUEST[ADDR_W-1:0];
  assign hit_power = wb_adr_i == prs_pkg::OFS_POWER[ADDR_W-1:0];
  assign hit_bo_ctrl = wb_adr_i == prs_pkg::OFS_BO_CTRL[ADDR_W-1:0];
  assign wr_enable = wr_go && hit_enable;
  assign wr_request = wr_go && hit_request;
  assign wr_power = wr_go && hit_power;
  assign wr_bo_ctrl = wr_go && hit_bo_ctrl;
  assign wr_data = wb_dat_i[7:0];
  assign rd_mux = hit_enable ? rd_enable :
                  hit_request ? rd_request :
                  hit_power ? rd_power :
                  hit_bo_ctrl ? rd_bo_ctrl : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= prs_pkg::RDATA_RST;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      wb_dat_o <= {24'h00_0000, rd_mux};
    end
  end

endmodule

// File: tb/prs_monitor.sv
`timescale 1ns/1ps
module prs_monitor #(
  parameter bit FULL_VARIANT = 1'b1,
  parameter int ADDR_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic brownout_reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic global_irq_enable,
  input wire logic peripheral_master_enable,
  input wire logic core_irq,
  input wire logic brownout_sw_enable
);
  localparam logic [7:0] IMPL =
    FULL_VARIANT ? prs_pkg::MASK_FULL : prs_pkg::MASK_REDUCED;
  logic rd_ack;
  assign rd_ack = wb_ack_o && !wb_we_i;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_pulse_a:
    assert property (req_s |=> ack_s) else $error("bad ack");
  master_gate_a:
    assert property (!peripheral_master_enable |=> !core_irq)
    else $error("irq without master enable");
  global_gate_a:
    assert property (!global_irq_enable |=> !core_irq)
    else $error("irq without global enable");
  rst_clear_a:
    assert property (disable iff (1'b0) rst |=> !core_irq && !wb_ack_o
      && !brownout_sw_enable && wb_dat_o == 32'h0000_0000)
    else $error("reset left state");
  brownout_clear_a:
    assert property (brownout_reset |=> !core_irq)
    else $error("irq after brown-out");
  enable_rsvd_a:
    assert property (rd_ack && wb_adr_i == prs_pkg::OFS_ENABLE |->
      (wb_dat_o[7:0] & ~IMPL) == 8'h00 && wb_dat_o[31:8] == 24'h00_0000)
    else $error("enable reserved bits");
  request_rsvd_a:
    assert property (rd_ack && wb_adr_i == prs_pkg::OFS_REQUEST |->
      (wb_dat_o[7:0] & ~IMPL) == 8'h00) else $error("flag reserved bits");
  power_rsvd_a:
    assert property (rd_ack && wb_adr_i == prs_pkg::OFS_POWER |->
      wb_dat_o[31:2] == 30'h0000_0000) else $error("power reserved bits");
  bo_off_a:
    assert property (rd_ack && wb_adr_i == prs_pkg::OFS_POWER
      && !brownout_sw_enable |-> !wb_dat_o[0]) else $error("bo bit set");
endmodule

bind prs_top prs_monitor #(.FULL_VARIANT(FULL_VARIANT), .ADDR_W(ADDR_W))
  u_mon (.ref_clk, .rst, .brownout_reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .global_irq_enable,
  .peripheral_master_enable, .core_irq, .brownout_sw_enable);

// File: tb/prs_periph_model.sv
`timescale 1ns/1ps
module prs_periph_model (
  input wire logic ref_clk,
  input wire logic [5:0] fire,
  output logic adc_done,
  output logic capcmp_capture,
  output logic capcmp_match,
  output logic comparator_out,
  output logic timer2_match,
  output logic timer1_overflow
);
  // Events are one-cycle pulses; comparator is a level that toggles
  logic cmp_level = 1'b0;
  assign comparator_out = cmp_level;
  always @(posedge ref_clk) begin
    {adc_done, capcmp_capture, capcmp_match} <= fire[5:3];
    {timer2_match, timer1_overflow} <= fire[1:0];
    cmp_level <= cmp_level ^ fire[2];
  end
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  localparam logic [7:0] A_EN = prs_pkg::OFS_ENABLE;
  localparam logic [7:0] A_REQ = prs_pkg::OFS_REQUEST;
  localparam logic [7:0] A_PWR = prs_pkg::OFS_POWER;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic brownout_reset = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = ZERO;
  logic [31:0] wb_dat_o, rd, r_dat_o, rd_r;
  logic wb_ack_o, core_irq, brownout_sw_enable;
  logic global_irq_enable = 1'b0;
  logic peripheral_master_enable = 1'b0;
  logic [2:0] capcmp_mode = 3'h1;
  logic [5:0] fire = 6'h00;
  logic adc_done, capcmp_capture, capcmp_match, comparator_out;
  logic timer2_match, timer1_overflow;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  initial forever #5 ref_clk = ~ref_clk;
  prs_periph_model src (.ref_clk, .fire, .adc_done, .capcmp_capture,
    .capcmp_match, .comparator_out, .timer2_match, .timer1_overflow);
  prs_top DUT (.ref_clk, .rst, .brownout_reset, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .global_irq_enable, .peripheral_master_enable, .adc_done,
    .capcmp_mode, .capcmp_capture, .capcmp_match, .comparator_out,
    .timer2_match, .timer1_overflow, .core_irq, .brownout_sw_enable);
  // Reduced variant shares the bus; only its read data is judged
  prs_top #(.FULL_VARIANT(1'b0)) DUT_R (.ref_clk, .rst, .brownout_reset,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i,
    .wb_dat_o(r_dat_o), .wb_ack_o(), .global_irq_enable,
    .peripheral_master_enable, .adc_done, .capcmp_mode, .capcmp_capture,
    .capcmp_match, .comparator_out, .timer2_match, .timer1_overflow,
    .core_irq(), .brownout_sw_enable());
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int k;
    k = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    {wb_adr_i, wb_dat_i} <= {a, d};
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    rd_r = r_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    if (wb_ack_o !== 1'b1) chk(ZERO, 32'h0000_0001);
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, ZERO);
    chk(rd, e);
  endtask
  task automatic pulse(input logic [5:0] f);
    fire <= f;
    @(posedge ref_clk);
    fire <= 6'h00;
    @(posedge ref_clk);
  endtask
  // Irq is registered: look 1 ns after the edge so its update has landed
  task automatic irq_is(input logic e);
    @(posedge ref_clk);
    #1 chk({31'h0000_0000, core_irq}, {31'h0000_0000, e});
    @(posedge ref_clk);
  endtask
  task automatic t_reset_vals;
    wr(8'h10, 32'hffff_ffff);
    for (int a = 0; a < 20; a += 4) rd_chk(8'(a), ZERO);
  endtask
  task automatic t_regs;
    wr(A_EN, 32'hffff_ffff);
    rd_chk(A_EN, {24'h00_0000, prs_pkg::MASK_FULL});
    chk(rd_r, {24'h00_0000, prs_pkg::MASK_REDUCED});
    wr(A_PWR, 32'hffff_ffff);
    rd_chk(A_PWR, 32'h0000_0002);
    wr(prs_pkg::OFS_BO_CTRL, 32'h0000_0001);
    rd_chk(A_PWR, 32'h0000_0003);
    brownout_reset <= 1'b1;
    @(posedge ref_clk);
    brownout_reset <= 1'b0;
    rd_chk(A_EN, ZERO);
    wr(prs_pkg::OFS_BO_CTRL, 32'h0000_0001);
    rd_chk(A_PWR, 32'h0000_0002);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd_chk(A_PWR, ZERO);
  endtask
  // Last two entries: capcmp events in a mode that must ignore them
  task automatic t_events;
    logic [5:0] f [8] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01,
      6'h18, 6'h10};
    logic [2:0] md [8] = '{3'h1, 3'h1, 3'h2, 3'h1, 3'h1, 3'h1, 3'h4, 3'h2};
    logic [7:0] ex [8] = '{8'h40, 8'h20, 8'h20, 8'h08, 8'h02, 8'h01,
      8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      capcmp_mode <= md[i];
      pulse(f[i]);
      rd_chk(A_REQ, {24'h00_0000, ex[i]});
      chk(rd_r, {24'h00_0000, ex[i] & prs_pkg::MASK_REDUCED});
      wr(A_REQ, ZERO);
    end
    // Event landing on the clearing write's edge must survive it
    fork
      wr(A_REQ, ZERO);
      begin
        fire <= 6'h01;
        @(posedge ref_clk);
        fire <= 6'h00;
      end
    join
    rd_chk(A_REQ, 32'h0000_0001);
  endtask
  task automatic t_irq;
    wr(A_REQ, ZERO);
    wr(A_EN, 32'h0000_0001);
    {global_irq_enable, peripheral_master_enable} <= 2'b11;
    pulse(6'h01);
    irq_is(1'b1);
    peripheral_master_enable <= 1'b0;
    irq_is(1'b0);
    {global_irq_enable, peripheral_master_enable} <= 2'b01;
    irq_is(1'b0);
    global_irq_enable <= 1'b1;
    irq_is(1'b1);
    wr(A_REQ, ZERO);
    irq_is(1'b0);
    // Flag whose own enable is off must stay silent
    pulse(6'h04);
    rd_chk(A_REQ, 32'h0000_0008);
    irq_is(1'b0);
  endtask
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      report_and_stop;
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset_vals;
    t_regs;
    t_events;
    t_irq;
    report_and_stop;
  end
endmodule
